// >>> bench/otf_ctrl_properties.sv
// port assertions for the offset trim and filter control block
`timescale 1ns/1ps
module otf_ctrl_properties (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic [11:0]              paddr,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire otf_pkg::otf_sample_t     samp_in,
	input wire otf_pkg::otf_cal_status_t cal_stat,
	input wire logic                     out_valid,
	input wire logic [11:0]              out_data,
	input wire logic                     conv_online
);
	import otf_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// register bus
	a_ready_access: assert property (psel && penable |-> pready) else $error("pready missing");
	a_ready_idle: assert property (!(psel && penable) |-> !pready) else $error("pready stray");
	a_err_access: assert property (pslverr |-> psel && penable) else $error("pslverr stray");
	a_err_unmapped: assert property (psel && !penable && paddr[11:2] == 10'h3ff |=> !penable || pslverr)
		else $error("pslverr missing");
	a_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
	// ==========
	// sample path and soak
	a_out_pulse: assert property (samp_in.valid |=> out_valid) else $error("out_valid late");
	a_out_quiet: assert property (!samp_in.valid |=> !out_valid && $stable(out_data))
		else $error("out moved");
	a_soak_restart: assert property (conv_online && cal_stat.conv_cal_done |=> !conv_online [*4])
		else $error("online kept");
	c_online: cover property ($rose(conv_online));
	c_err: cover property (pslverr);
	c_out: cover property (out_valid);
endmodule : otf_ctrl_properties

bind otf_ctrl otf_ctrl_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .samp_in(samp_in),
	.cal_stat(cal_stat), .out_valid(out_valid), .out_data(out_data), .conv_online(conv_online));

// >>> bench/tb_top.sv
// self-checking bench for the offset trim and filter control block
`timescale 1ns/1ps
`include "otf_defines.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
	import otf_pkg::*;
	logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic            pready, pslverr, out_valid, conv_online, er;
	logic [11:0]     paddr = 0, out_data;
	logic [31:0]     pwdata = 0, prdata, rd;
	logic [3:0]      bwr[3] = '{4'h0, 4'h6, 4'hf};
	otf_sample_t     samp_in = '0;
	otf_cal_status_t cal_stat = '0;
	int              err_count = 0, n_checks = 0, i, v, trim[2] = '{2048, 2048};
	otf_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.samp_in(samp_in), .cal_stat(cal_stat), .out_valid(out_valid), .out_data(out_data),
		.conv_online(conv_online));
	// 20 MHz clock
	initial forever #25 pclk = ~pclk;
	// one apb transfer, held until pready is sampled
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask : apb
	// one converter sample, result due one cycle later
	task automatic smp(input logic b, input logic [1:0] bk, input logic [11:0] d);
		@(posedge pclk);
		samp_in <= '{1'b1, b, bk, d};
		@(posedge pclk);
		samp_in.valid <= 1'b0;
		#1;
		`CHK("out_valid", 1'b1, out_valid)
	endtask : smp
	// calibration done pulse
	task automatic pulse();
		@(posedge pclk);
		cal_stat.conv_cal_done <= 1'b1;
		@(posedge pclk);
		cal_stat.conv_cal_done <= 1'b0;
		#1;
	endtask : pulse
	// unfiltered reference: trim removed, midscale restored, saturated
	function automatic logic [11:0] model(input logic b, input logic [11:0] d);
		int c;
		c = $signed(d) - trim[b] + 2048;
		if (c > 2047) c = 2047;
		if (c < -2048) c = -2048;
		return c[11:0];
	endfunction : model
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	// ==========
	// main sequence
	initial begin
		v = $urandom(32'hb3f5);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OTF_IDX_TRIM_A, 32'h0);
		`CHK("trim_a_rst", 32'h800, rd)
		apb(1'b0, `OTF_IDX_TRIM_B, 32'h0);
		`CHK("trim_b_rst", 32'h800, rd)
		apb(1'b0, `OTF_IDX_FILT_HI, 32'h0);
		`CHK("filt_hi_rst", 32'h33, rd)
		apb(1'b0, `OTF_IDX_FILT_LO, 32'h0);
		`CHK("filt_lo_rst", 32'h0, rd)
		apb(1'b0, 10'h3ff, 32'h0);
		`CHK("unmapped_rd", 32'h0, rd)
		apb(1'b1, 10'h3ff, 32'hffff_ffff);
		`CHK("unmapped_err", 1'b1, er)
		apb(1'b1, `OTF_IDX_FILT_LO, 32'hff);
		apb(1'b0, `OTF_IDX_FILT_LO, 32'h0);
		`CHK("filt_lo_rsvd", 32'h1, rd)
		// random trims, each applied to its own input
		for (i = 0; i < 40; i++) begin
			v = $urandom;
			apb(1'b1, i[0] ? `OTF_IDX_TRIM_B : `OTF_IDX_TRIM_A, v);
			trim[i[0]] = v & 32'hfff;
			apb(1'b0, i[0] ? `OTF_IDX_TRIM_B : `OTF_IDX_TRIM_A, 32'h0);
			`CHK("trim_rd", trim[i[0]], rd)
			v = $urandom;
			smp(v[12], v[14:13], v[11:0]);
			`CHK("out_data", model(v[12], v[11:0]), out_data)
		end
		cal_stat.fg_busy <= 1'b1;
		apb(1'b1, `OTF_IDX_CAL_CTRL, 32'h1);
		apb(1'b0, `OTF_IDX_CAL_STAT, 32'h0);
		`CHK("stat_busy", 32'h8, rd)
		cal_stat <= '{1'b0, 1'b1, 1'b0, 1'b0};
		apb(1'b0, `OTF_IDX_TRIM_A, 32'h0);
		`CHK("trim_a_fg", trim[0], rd)
		apb(1'b1, `OTF_IDX_CAL_CTRL, 32'h7);
		cal_stat.cal_halted_flag <= 1'b1;
		apb(1'b0, `OTF_IDX_CAL_STAT, 32'h0);
		`CHK("stat_halt", 32'h6, rd)
		apb(1'b0, `OTF_IDX_TRIM_B, 32'h0);
		`CHK("trim_b_halt", trim[1], rd)
		cal_stat <= '0;
		apb(1'b1, `OTF_IDX_CAL_CTRL, 32'h0);
		// filter alone: dc removed, settle pulse ignored
		apb(1'b1, `OTF_IDX_TRIM_A, 32'h800);
		apb(1'b1, `OTF_IDX_FILT_HI, 32'h11);
		apb(1'b1, `OTF_IDX_FILT_LO, 32'h0);
		apb(1'b1, `OTF_IDX_CAL_CTRL, 32'h9);
		pulse();
		for (i = 0; i < 20000; i++) smp(1'b0, i[1:0], 12'd400);
		`CHK("online_off", 1'b0, conv_online)
		`CHK("dc_gone", 1'b1, $signed(out_data) < 12'sd9 && $signed(out_data) > -12'sd9)
		for (i = 0; i < 3; i++) begin
			apb(1'b1, `OTF_IDX_FILT_HI, {24'h0, bwr[i], 4'h1});
			smp(1'b0, 2'd0, 12'd400);
			`CHK("bw_rsvd", 12'd400, out_data)
		end
		apb(1'b1, `OTF_IDX_FILT_HI, 32'h11);
		apb(1'b1, `OTF_IDX_FILT_LO, 32'h1);
		smp(1'b0, 2'd1, 12'd400);
		`CHK("dc_kept", 1'b1, out_data > 12'd397 && out_data < 12'd403)
		// soak of 2^10 samples before going online
		apb(1'b1, `OTF_IDX_CAL_CTRL, 32'hb);
		pulse();
		for (i = 0; i < 1000; i++) smp(1'b0, i[1:0], 12'd400);
		`CHK("soaking", 1'b0, conv_online)
		for (i = 0; i < 40; i++) smp(1'b0, i[1:0], 12'd400);
		`CHK("online", 1'b1, conv_online)
		apb(1'b0, `OTF_IDX_CAL_STAT, 32'h0);
		`CHK("stat_online", 1'b1, rd[0])
		pulse();
		`CHK("resoak", 1'b0, conv_online)
		complete_run();
	end
endmodule : tb_top

// >>> src/otf_ctrl.sv
// offset trim and IIR offset filter control with APB register slave
`timescale 1ns/1ps
`include "otf_defines.svh"
module otf_ctrl (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// converter samples and calibration status
	input  wire otf_pkg::otf_sample_t    samp_in,
	input  wire otf_pkg::otf_cal_status_t cal_stat,
	// corrected sample and online flag
	output logic                         out_valid,
	output logic      [11:0]             out_data,
	output logic                         conv_online
);
	import otf_pkg::*;

	otf_regs_t r;
	otf_regs_t next_r;

	//==============================================================
	// helpers
	// shift for a bandwidth code, zero for reserved codes
	function automatic logic [4:0] bw_shift(input logic [3:0] code);
		if (code >= `OTF_BW_MIN && code <= `OTF_BW_MAX) begin
			return `OTF_SHIFT_BASE + {1'b0, code};
		end
		return 5'h00;
	endfunction : bw_shift

	// clamp a wide signed value to 12-bit signed
	function automatic logic [11:0] sat12(input logic signed [15:0] v);
		if (v > 16'sd2047) begin
			return 12'h7ff;
		end
		if (v < -16'sd2048) begin
			return 12'h800;
		end
		return v[11:0];
	endfunction : sat12

	// sign-extend a 14-bit value to 16 bits
	function automatic logic signed [15:0] sx16(input logic signed [13:0] v);
		return {{2{v[13]}}, v};
	endfunction : sx16

	// sign-extend a 28-bit estimate to 30 bits
	function automatic logic signed [29:0] sx30(input logic [27:0] v);
		return {{2{v[27]}}, v};
	endfunction : sx30

	// settle length in samples, one sample for reserved codes
	function automatic logic [24:0] settle_len(input logic [3:0] code);
		logic [4:0] sh;
		sh = bw_shift(code);
		if (sh == 5'h00) begin
			return 25'h0000001;
		end
		return 25'h0000001 << sh;
	endfunction : settle_len

	// one iir step: estimate moves by the error times two to minus shift
	function automatic logic [27:0] iir_step(input logic [27:0] est, input logic signed [27:0] e,
		input logic [4:0] sh);
		logic signed [27:0] step;
		step = e >>> sh;
		return est + $unsigned(step);
	endfunction : iir_step

	// trim word of the input being sampled
	function automatic logic [11:0] trim_pick(input otf_regs_t s, input logic sel_b);
		return sel_b ? s.conv2_input_b_trim : s.conv2_input_a_trim;
	endfunction : trim_pick

	// trim removed and midscale restored, 14 bits cannot overflow
	function automatic logic signed [13:0] correct(input logic [11:0] d, input logic [11:0] t);
		return $signed({{2{d[11]}}, d}) - $signed({2'b00, t}) + 14'sd2048;
	endfunction : correct

	// mean of the four bank estimates
	function automatic logic signed [27:0] mean4(input logic [3:0][27:0] e);
		logic signed [29:0] sum;
		sum = sx30(e[0]) + sx30(e[1]) + sx30(e[2]) + sx30(e[3]);
		return sum[29:2];
	endfunction : mean4

	// offset to remove: bank mismatch only, or the whole estimate
	function automatic logic signed [27:0] offset_term(input logic restore, input logic [27:0] own,
		input logic signed [27:0] mean);
		if (restore) begin
			return $signed(own) - mean;
		end
		return $signed(own);
	endfunction : offset_term

	// register read decode, bit 32 flags an unmapped index
	function automatic logic [32:0] read_word(input logic [9:0] i, input otf_regs_t s,
		input otf_cal_status_t c);
		logic [32:0] w;
		w = '0;
		case (i)
			`OTF_IDX_TRIM_A:   w[11:0] = s.conv2_input_a_trim;
			`OTF_IDX_TRIM_B:   w[11:0] = s.conv2_input_b_trim;
			`OTF_IDX_FILT_LO:  w[0]    = s.keep_low_freq_content;
			`OTF_IDX_FILT_HI:  w[7:0]  = {s.filter_bandwidth_code, s.filter_settle_code};
			`OTF_IDX_CAL_CTRL: w[3:0]  = {s.offset_filter_enable,
				s.background_offset_cal_enable, s.background_cal_enable, s.offset_cal_enable};
			`OTF_IDX_CAL_STAT: w[3:0]  = {c.fg_busy, c.cal_halted_flag,
				c.foreground_cal_complete, s.state == otf_st_online};
			default:           w[32]   = 1'b1;
		endcase
		return w;
	endfunction : read_word

	// register write decode, reserved bits dropped, unmapped index ignored
	function automatic otf_regs_t apply_write(input otf_regs_t s, input logic [9:0] i, input logic [31:0] d);
		otf_regs_t n;
		n = s;
		case (i)
			`OTF_IDX_TRIM_A: begin
				n.conv2_input_a_trim = d[`OTF_TRIM_MSB:0];
			end
			`OTF_IDX_TRIM_B: begin
				n.conv2_input_b_trim = d[`OTF_TRIM_MSB:0];
			end
			// restore control, upper bits reserved
			`OTF_IDX_FILT_LO: begin
				n.keep_low_freq_content = d[0];
			end
			`OTF_IDX_FILT_HI: begin
				n.filter_bandwidth_code = d[`OTF_BW_LSB+3:`OTF_BW_LSB];
				n.filter_settle_code    = d[3:0];
			end
			// calibration enables
			`OTF_IDX_CAL_CTRL: begin
				n.offset_cal_enable            = d[0];
				n.background_cal_enable        = d[1];
				n.background_offset_cal_enable = d[2];
				n.offset_filter_enable         = d[3];
			end
			default: ;
		endcase
		return n;
	endfunction : apply_write

	//==============================================================
	// combinational next state
	logic [9:0]         idx;
	logic               setup;
	logic               wr_en;
	// sample correction and filter
	logic [4:0]         shift;
	logic [11:0]        trim_sel;
	logic signed [13:0] corr;
	logic signed [27:0] target;
	logic signed [27:0] err;
	logic signed [27:0] est_mean;
	logic signed [27:0] remove;
	logic signed [15:0] filtered;
	logic               filt_on;
	logic               soak_mode;
	logic [24:0]        soak_len;

	always_comb begin
		next_r     = r;
		idx        = paddr[11:2];
		setup      = psel && !penable;
		wr_en      = psel && penable && pwrite;
		shift      = bw_shift(r.filter_bandwidth_code);
		soak_len   = settle_len(r.filter_settle_code);
		trim_sel   = trim_pick(r, samp_in.input_b);
		corr       = correct(samp_in.data, trim_sel);
		target     = $signed({corr, 14'h0000});
		err        = target - $signed(r.est[samp_in.bank]);
		est_mean   = mean4(r.est);
		remove     = offset_term(r.keep_low_freq_content, r.est[samp_in.bank], est_mean);
		filtered   = sx16(corr) - $signed(remove[27:`OTF_FRAC]);
		soak_mode  = r.offset_filter_enable && r.background_cal_enable;
		filt_on    = r.offset_filter_enable && (shift != 5'h00)
			&& (!soak_mode || r.state == otf_st_online);

		// apb read data and error captured in setup phase
		if (setup) begin
			{next_r.pslverr, next_r.prdata} = read_word(idx, r, cal_stat);
		end

		// apb writes take effect at the access edge
		if (wr_en) begin
			next_r = apply_write(next_r, idx, pwdata);
		end

		// coefficient is two to minus shift
		// code 1 widest bandwidth, code 5 narrowest
		if (samp_in.valid && r.offset_filter_enable && shift != 5'h00) begin
			next_r.est[samp_in.bank] = iir_step(r.est[samp_in.bank], err, shift);
		end
		// estimates restart from zero while the filter is off
		if (!r.offset_filter_enable) begin
			next_r.est = '0;
		end

		// registered corrected sample
		next_r.out_valid = samp_in.valid;
		if (samp_in.valid) begin
			next_r.out_data = filt_on ? sat12(filtered) : sat12(sx16(corr));
		end

		case (r.state)
			otf_st_offline: begin
				if (soak_mode && cal_stat.conv_cal_done) begin
					next_r.state    = otf_st_soak;
					next_r.soak_cnt = soak_len;
				end
			end
			// settle counted in samples
			otf_st_soak: begin
				// enables dropped mid-settle: back offline
				if (!soak_mode) begin
					next_r.state = otf_st_offline;
				end else if (r.soak_cnt <= 25'h0000001) begin
					next_r.state = otf_st_online;
				// idle cycles do not count
				end else if (samp_in.valid) begin
					next_r.soak_cnt = r.soak_cnt - 25'h0000001;
				end
			end
			// recalibration or disable leaves online
			otf_st_online: begin
				if (!soak_mode || cal_stat.conv_cal_done) begin
					next_r.state    = soak_mode ? otf_st_soak : otf_st_offline;
					next_r.soak_cnt = soak_len;
				end
			end
			default: next_r.state = otf_st_offline;
		endcase
	end

	//==============================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// datapath and bus registers cleared
			r.est                          <= '0;
			r.soak_cnt                     <= '0;
			r.prdata                       <= '0;
			r.pslverr                      <= 1'b0;
			r.out_valid                    <= 1'b0;
			r.out_data                     <= '0;
			r.conv2_input_a_trim           <= `OTF_TRIM_FACTORY;
			r.conv2_input_b_trim           <= `OTF_TRIM_FACTORY;
			r.keep_low_freq_content        <= 1'(`OTF_FILT_LO_RST);
			r.filter_bandwidth_code        <= 4'(`OTF_FILT_HI_RST >> `OTF_BW_LSB);
			r.filter_settle_code           <= 4'(`OTF_FILT_HI_RST);
			// calibration enables off
			{r.offset_filter_enable, r.background_offset_cal_enable,
				r.background_cal_enable, r.offset_cal_enable} <= `OTF_CTRL_RST;
			r.state                        <= otf_st_offline;
		end else begin
			r <= next_r;
		end
	end

	//==============================================================
	// outputs
	assign prdata      = r.prdata;
	// error shown only in the access phase
	assign pslverr     = r.pslverr && psel && penable;
	// zero wait states: ready in every access cycle
	assign pready      = psel && penable;
	assign out_valid   = r.out_valid;
	assign out_data    = r.out_data;
	assign conv_online = (r.state == otf_st_online);
endmodule : otf_ctrl

// >>> src/otf_defines.svh
// constants for the offset trim and filter control block
//==============================================================
`ifndef OTF_DEFINES_SVH
`define OTF_DEFINES_SVH
//==============================================================
// register indices, byte address is four times the index
`define OTF_IDX_TRIM_A   10'h092
`define OTF_IDX_TRIM_B   10'h094
`define OTF_IDX_FILT_LO  10'h097
`define OTF_IDX_FILT_HI  10'h098
`define OTF_IDX_CAL_CTRL 10'h0a0
`define OTF_IDX_CAL_STAT 10'h0a1
//==============================================================
// field positions and reset values
`define OTF_TRIM_MSB     11
`define OTF_BW_LSB       4
`define OTF_FILT_HI_RST  8'h33
`define OTF_FILT_LO_RST  8'h00
`define OTF_CTRL_RST     4'h0
`define OTF_TRIM_FACTORY 12'h800
`define OTF_BW_MIN       4'h1
`define OTF_BW_MAX       4'h5
`define OTF_SHIFT_BASE   5'h09
`define OTF_FRAC         14
`endif

// >>> src/otf_pkg.sv
// types for the offset trim and filter control block
package otf_pkg;
	typedef enum logic [2:0] {
		otf_st_offline = 3'b001,
		otf_st_soak    = 3'b010,
		otf_st_online  = 3'b100
	} otf_state_t;

	typedef struct packed {
		logic        valid;
		logic        input_b;
		logic [1:0]  bank;
		logic [11:0] data;
	} otf_sample_t;

	typedef struct packed {
		logic fg_busy;
		logic foreground_cal_complete;
		logic cal_halted_flag;
		logic conv_cal_done;
	} otf_cal_status_t;

	typedef struct packed {
		logic [11:0]      conv2_input_a_trim;
		logic [11:0]      conv2_input_b_trim;
		logic             keep_low_freq_content;
		logic [3:0]       filter_bandwidth_code;
		logic [3:0]       filter_settle_code;
		logic             offset_cal_enable;
		logic             background_cal_enable;
		logic             background_offset_cal_enable;
		logic             offset_filter_enable;
		logic [3:0][27:0] est;
		otf_state_t       state;
		logic [24:0]      soak_cnt;
		logic [31:0]      prdata;
		logic             pslverr;
		logic             out_valid;
		logic [11:0]      out_data;
	} otf_regs_t;
endpackage : otf_pkg
